// File: crbc_cfg.svh
/*
 * offsets, field positions, reset values and write masks of the receive
 * buffer control block; assumes an 8-bit register port with byte offsets.
 */
`ifndef CRBC_CFG_SVH
`define CRBC_CFG_SVH

`define CRBC_OFS_PIN_CTRL 8'h0c
`define CRBC_OFS_INT_EN 8'h2b
`define CRBC_OFS_INT_FLAG 8'h2c
`define CRBC_OFS_ERR_FLAG 8'h2d
`define CRBC_OFS_HIGH_PRIORITY_BUFFER_CTRL 8'h60
`define CRBC_OFS_HIGH_PRIORITY_BUFFER_SIDH 8'h61
`define CRBC_OFS_HIGH_PRIORITY_BUFFER_SIDL 8'h62
`define CRBC_OFS_LOW_PRIORITY_BUFFER_CTRL 8'h70
`define CRBC_OFS_LOW_PRIORITY_BUFFER_SIDH 8'h71
`define CRBC_OFS_LOW_PRIORITY_BUFFER_SIDL 8'h72

`define CRBC_RST_REG 8'h00
`define CRBC_WMASK_CTRL0 8'h64
`define CRBC_WMASK_CTRL1 8'h60
`define CRBC_WMASK_PIN_CTRL 8'h3f
`define CRBC_WMASK_INT 8'h23
`define CRBC_WMASK_ERR_FLAG 8'hc0

`define CRBC_BIT_PIN_MODE 0
`define CRBC_BIT_PIN_EN 2
`define CRBC_BIT_PIN_LVL 4
`define CRBC_BIT_RX0_FULL 0
`define CRBC_BIT_RX1_FULL 1
`define CRBC_BIT_ERR_INT 5
`define CRBC_BIT_OVR0 6
`define CRBC_BIT_OVR1 7
`define CRBC_BIT_ROLLOVER_ENABLE 2

`define CRBC_MODE_ANY 2'b11
`define CRBC_MODE_EXT 2'b10
`define CRBC_MODE_STD 2'b01

`define CRBC_FIFO_DEPTH 16
`define CRBC_NUM_FILT 6

`endif

// File: crbc_pkg.sv
/*
 * types shared by the receive buffer control block;
 * assumes crbc_cfg.svh is on the include path.
 */
package crbc_pkg;
`include "crbc_cfg.svh"

   typedef struct packed {
      logic [10:0] standard_identifier;
      logic srr;
      logic ide;
      logic [1:0] extended_identifier;
      logic rtr;
   } crbc_id_s;

   typedef struct packed {
      crbc_id_s id;
      logic err;
      logic [`CRBC_NUM_FILT-1:0] id_match;
      logic [`CRBC_NUM_FILT-1:0] data_match;
   } crbc_msg_s;

   localparam int CRBC_MSG_W = $bits(crbc_msg_s);
endpackage

// File: crbc_stream_if.sv
/*
 * valid/ready carrier between the top module and its message fifo;
 * assumes both ends run on the same clock.
 */
`timescale 1ns/100ps
interface crbc_stream_if #(parameter int W = 8);
   logic valid;
   logic ready;
   logic [W-1:0] data;
   modport src (output valid, output data, input ready);
   modport snk (input valid, input data, output ready);
endinterface

// File: crbc_fifo.sv
/*
 * message fifo, flip-flop storage, registered valid and ready;
 * assumes a single clock and an active-low asynchronous reset.
 */
`timescale 1ns/100ps
module crbc_fifo #(
   parameter int W = 8,
   parameter int DEPTH = 16
) (
   input wire logic clk_sys_i,
   input wire logic rstn_i,
   crbc_stream_if.snk in_if,
   crbc_stream_if.src out_if
);
   localparam int AW = $clog2(DEPTH);
   logic [W-1:0] mem_reg [DEPTH];
   logic [AW-1:0] wr_reg, wr_next, rd_reg, rd_next;
   logic [AW:0] cnt_reg, cnt_next;
   logic in_rdy_reg, in_rdy_next, out_vld_reg, out_vld_next;
   logic push, pop;

   assign push = in_if.valid && in_rdy_reg;
   assign pop = out_vld_reg && out_if.ready;
   assign in_if.ready = in_rdy_reg;
   assign out_if.valid = out_vld_reg;
   assign out_if.data = mem_reg[rd_reg];

   always_comb begin
      wr_next = push ? wr_reg + 1'b1 : wr_reg;
      rd_next = pop ? rd_reg + 1'b1 : rd_reg;
      cnt_next = cnt_reg + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
      in_rdy_next = cnt_next != (AW+1)'(DEPTH);
      out_vld_next = cnt_next != '0;
   end

   always_ff @(posedge clk_sys_i or negedge rstn_i) begin
      if (!rstn_i) begin
         wr_reg <= '0;
         rd_reg <= '0;
         cnt_reg <= '0;
         in_rdy_reg <= 1'b0;
         out_vld_reg <= 1'b0;
      end else begin
         wr_reg <= wr_next;
         rd_reg <= rd_next;
         cnt_reg <= cnt_next;
         in_rdy_reg <= in_rdy_next;
         out_vld_reg <= out_vld_next;
      end
   end

   // storage has no reset, only written on push
   always_ff @(posedge clk_sys_i) begin
      if (push) begin
         mem_reg[wr_reg] <= in_if.data;
      end
   end
endmodule // crbc_fifo

// File: crbc_top.sv
/*
 * receive buffer control: acceptance of assembled messages into two
 * prioritized receive buffers, rollover, overflow, receive flags, the
 * interrupt output and the two buffer-full pins with their register map.
 * assumes the protocol engine and the filter compare logic run on
 * clk_sys_i and hand over one finished message per valid/ready beat, and
 * that a command decoder on the host side drives the register port.
 */
`timescale 1ns/100ps
module crbc_top
   import crbc_pkg::*;
(
   input wire logic clk_sys_i,
   input wire logic rstn_i,
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   input wire logic [7:0] reg_addr_i,
   input wire logic [7:0] reg_wdata_i,
   input wire logic [7:0] reg_mask_i,
   output logic [7:0] reg_rdata_o,
   input wire logic msg_valid_i,
   output logic msg_ready_o,
   input wire logic msg_err_i,
   input wire logic [10:0] msg_sid_i,
   input wire logic msg_srr_i,
   input wire logic msg_ide_i,
   input wire logic [1:0] msg_eid_i,
   input wire logic msg_rtr_i,
   input wire logic [5:0] msg_id_match_i,
   input wire logic [5:0] msg_data_match_i,
   input wire logic [5:0] filt_ext_i,
   output logic err_frame_o,
   output logic int_n_o,
   output logic [1:0] full_pin_o,
   output logic [1:0] full_pin_oe_o
);
   // masked write as used by both plain write and bit-modify
   function automatic logic [7:0] bit_mod(input logic [7:0] old, input logic [7:0] wmask);
      logic [7:0] m;
      m = reg_mask_i & wmask;
      return (old & ~m) | (reg_wdata_i & m);
   endfunction

   // one filter of one buffer against the message
   function automatic logic filt_ok(input logic [1:0] mode, input crbc_msg_s m, input int k);
      logic r;
      r = 1'b0;
      if (mode == `CRBC_MODE_ANY) begin
         r = 1'b1;
      end else if (m.err) begin
         r = 1'b0;
      end else if (m.id.ide) begin
         r = (mode != `CRBC_MODE_STD) && m.id_match[k] && filt_ext_i[k];
      end else begin
         r = (mode != `CRBC_MODE_EXT) && m.id_match[k] && !filt_ext_i[k]
             && ((mode == `CRBC_MODE_STD) || m.data_match[k]);
      end
      return r;
   endfunction

   logic msg_in_rdy, msg_push;
   crbc_stream_if #(.W(CRBC_MSG_W)) in_if ();
   crbc_stream_if #(.W(CRBC_MSG_W)) out_if ();

   crbc_fifo #(.W(CRBC_MSG_W), .DEPTH(`CRBC_FIFO_DEPTH)) u_fifo (
      .clk_sys_i(clk_sys_i),
      .rstn_i(rstn_i),
      .in_if(in_if),
      .out_if(out_if)
   );

   crbc_msg_s head;
   assign in_if.valid = msg_valid_i;
   assign in_if.data = {msg_sid_i, msg_srr_i, msg_ide_i, msg_eid_i, msg_rtr_i, msg_err_i,
                        msg_id_match_i, msg_data_match_i};
   assign msg_in_rdy = in_if.ready;
   assign msg_ready_o = msg_in_rdy;
   assign msg_push = msg_valid_i && msg_in_rdy;
   assign head = out_if.data;
   // drain waits while the host writes the flag register
   assign out_if.ready = !(reg_wr_i && reg_addr_i == `CRBC_OFS_INT_FLAG);

   // register state
   logic [7:0] pin_ctrl_reg, pin_ctrl_next, int_en_reg, int_en_next;
   logic [7:0] int_flag_reg, int_flag_next, err_flag_reg, err_flag_next;
   logic [7:0] ctrl0_reg, ctrl0_next, ctrl1_reg, ctrl1_next;
   logic [2:0] filhit1_reg, filhit1_next;
   logic filhit0_reg, filhit0_next;
   logic [1:0] rtr_reg, rtr_next;
   crbc_id_s id0_reg, id0_next, id1_reg, id1_next;
   logic [7:0] rdata_reg, rdata_next;
   logic err_frame_reg, err_frame_next, int_n_reg, int_n_next;
   logic [1:0] pin_reg, pin_next, pin_oe_reg, pin_oe_next;

   // acceptance decision for the head message
   logic pop, hit0, hit1, high_priority_buffer_full, low_priority_buffer_full;
   logic load0, load1, ovr0, ovr1, hit0_code;
   logic [2:0] hit1_code, load1_code;
   logic [5:0] ok;

   always_comb begin
      pop = out_if.valid && out_if.ready;
      high_priority_buffer_full = int_flag_reg[`CRBC_BIT_RX0_FULL];
      low_priority_buffer_full = int_flag_reg[`CRBC_BIT_RX1_FULL];
      for (int k = 0; k < `CRBC_NUM_FILT; k++) begin
         ok[k] = filt_ok((k < 2) ? ctrl0_reg[6:5] : ctrl1_reg[6:5], head, k);
      end
      hit0 = ok[0] || ok[1];
      hit0_code = !ok[0];
      hit1 = |ok[5:2];
      hit1_code = 3'h5;
      for (int k = 5; k >= 2; k--) begin
         if (ok[k]) begin
            hit1_code = 3'(k);
         end
      end
      load0 = 1'b0;
      load1 = 1'b0;
      ovr0 = 1'b0;
      ovr1 = 1'b0;
      load1_code = hit1_code;
      if (pop && hit0) begin
         if (!high_priority_buffer_full) begin
            load0 = 1'b1;
         end else if (ctrl0_reg[`CRBC_BIT_ROLLOVER_ENABLE]) begin
            load1_code = {2'h0, hit0_code};
            if (!low_priority_buffer_full) begin
               load1 = 1'b1;
            end else begin
               ovr1 = 1'b1;
            end
         end else begin
            ovr0 = 1'b1;
         end
      end else if (pop && hit1) begin
         if (!low_priority_buffer_full) begin
            load1 = 1'b1;
         end else begin
            ovr1 = 1'b1;
         end
      end
   end

   // host writes, then hardware events; a set wins over a host clear
   always_comb begin
      logic wr;
      wr = reg_wr_i;
      pin_ctrl_next = pin_ctrl_reg;
      int_en_next = int_en_reg;
      int_flag_next = int_flag_reg;
      err_flag_next = err_flag_reg;
      ctrl0_next = ctrl0_reg;
      ctrl1_next = ctrl1_reg;
      if (wr) begin
         case (reg_addr_i)
            `CRBC_OFS_PIN_CTRL: pin_ctrl_next = bit_mod(pin_ctrl_reg, `CRBC_WMASK_PIN_CTRL);
            `CRBC_OFS_INT_EN: int_en_next = bit_mod(int_en_reg, `CRBC_WMASK_INT);
            `CRBC_OFS_INT_FLAG: int_flag_next = bit_mod(int_flag_reg, `CRBC_WMASK_INT);
            `CRBC_OFS_ERR_FLAG: err_flag_next = bit_mod(err_flag_reg, `CRBC_WMASK_ERR_FLAG);
            `CRBC_OFS_HIGH_PRIORITY_BUFFER_CTRL: ctrl0_next = bit_mod(ctrl0_reg, `CRBC_WMASK_CTRL0);
            `CRBC_OFS_LOW_PRIORITY_BUFFER_CTRL: ctrl1_next = bit_mod(ctrl1_reg, `CRBC_WMASK_CTRL1);
            default: ;
         endcase
      end
      if (load0) begin
         int_flag_next[`CRBC_BIT_RX0_FULL] = 1'b1;
      end
      if (load1) begin
         int_flag_next[`CRBC_BIT_RX1_FULL] = 1'b1;
      end
      if (ovr0) begin
         err_flag_next[`CRBC_BIT_OVR0] = 1'b1;
      end
      if (ovr1) begin
         err_flag_next[`CRBC_BIT_OVR1] = 1'b1;
      end
      if (ovr0 || ovr1) begin
         int_flag_next[`CRBC_BIT_ERR_INT] = 1'b1;
      end
   end

   // stored message fields and status bits
   always_comb begin
      id0_next = id0_reg;
      id1_next = id1_reg;
      filhit0_next = filhit0_reg;
      filhit1_next = filhit1_reg;
      rtr_next = rtr_reg;
      if (load0) begin
         id0_next = head.id;
         filhit0_next = hit0_code;
         rtr_next[0] = head.id.ide ? head.id.rtr : head.id.srr;
      end
      if (load1) begin
         id1_next = head.id;
         filhit1_next = load1_code;
         rtr_next[1] = head.id.ide ? head.id.rtr : head.id.srr;
      end
   end

   // read data, error frame, interrupt and pins
   always_comb begin
      logic [1:0] irq_mode;
      irq_mode = pin_ctrl_reg[3:2] & pin_ctrl_reg[1:0];
      rdata_next = rdata_reg;
      if (reg_rd_i) begin
         case (reg_addr_i)
            `CRBC_OFS_PIN_CTRL: rdata_next = {2'h0, pin_ctrl_reg[5:4] & ~irq_mode,
                                              pin_ctrl_reg[3:0]};
            `CRBC_OFS_INT_EN: rdata_next = int_en_reg;
            `CRBC_OFS_INT_FLAG: rdata_next = int_flag_reg;
            `CRBC_OFS_ERR_FLAG: rdata_next = err_flag_reg;
            `CRBC_OFS_HIGH_PRIORITY_BUFFER_CTRL: rdata_next = {1'b0, ctrl0_reg[6:5], 1'b0, rtr_reg[0],
                                               ctrl0_reg[2], ctrl0_reg[2],
                                               filhit0_reg};
            `CRBC_OFS_LOW_PRIORITY_BUFFER_CTRL: rdata_next = {1'b0, ctrl1_reg[6:5], 1'b0, rtr_reg[1],
                                               filhit1_reg};
            `CRBC_OFS_HIGH_PRIORITY_BUFFER_SIDH: rdata_next = id0_reg.standard_identifier[10:3];
            `CRBC_OFS_LOW_PRIORITY_BUFFER_SIDH: rdata_next = id1_reg.standard_identifier[10:3];
            `CRBC_OFS_HIGH_PRIORITY_BUFFER_SIDL: rdata_next = {id0_reg.standard_identifier[2:0], id0_reg.srr, id0_reg.ide,
                                               1'b0, id0_reg.extended_identifier};
            `CRBC_OFS_LOW_PRIORITY_BUFFER_SIDL: rdata_next = {id1_reg.standard_identifier[2:0], id1_reg.srr, id1_reg.ide,
                                               1'b0, id1_reg.extended_identifier};
            default: rdata_next = 8'h00;
         endcase
      end
      err_frame_next = msg_push && msg_err_i;
      int_n_next = !(|(int_flag_reg & int_en_reg & `CRBC_WMASK_INT));
      for (int n = 0; n < 2; n++) begin
         pin_oe_next[n] = pin_ctrl_reg[`CRBC_BIT_PIN_EN + n];
         if (pin_ctrl_reg[`CRBC_BIT_PIN_MODE + n]) begin
            pin_next[n] = !int_flag_reg[n];
         end else begin
            pin_next[n] = pin_ctrl_reg[`CRBC_BIT_PIN_LVL + n];
         end
      end
   end

   always_ff @(posedge clk_sys_i or negedge rstn_i) begin
      if (!rstn_i) begin
         pin_ctrl_reg <= `CRBC_RST_REG;
         int_en_reg <= `CRBC_RST_REG;
         int_flag_reg <= `CRBC_RST_REG;
         err_flag_reg <= `CRBC_RST_REG;
         ctrl0_reg <= `CRBC_RST_REG;
         ctrl1_reg <= `CRBC_RST_REG;
         filhit0_reg <= 1'b0;
         filhit1_reg <= 3'h0;
         rtr_reg <= 2'h0;
         id0_reg <= '0;
         id1_reg <= '0;
         rdata_reg <= 8'h00;
         err_frame_reg <= 1'b0;
         int_n_reg <= 1'b1;
         pin_reg <= 2'h3;
         pin_oe_reg <= 2'h0;
      end else begin
         pin_ctrl_reg <= pin_ctrl_next;
         int_en_reg <= int_en_next;
         int_flag_reg <= int_flag_next;
         err_flag_reg <= err_flag_next;
         ctrl0_reg <= ctrl0_next;
         ctrl1_reg <= ctrl1_next;
         filhit0_reg <= filhit0_next;
         filhit1_reg <= filhit1_next;
         rtr_reg <= rtr_next;
         id0_reg <= id0_next;
         id1_reg <= id1_next;
         rdata_reg <= rdata_next;
         err_frame_reg <= err_frame_next;
         int_n_reg <= int_n_next;
         pin_reg <= pin_next;
         pin_oe_reg <= pin_oe_next;
      end
   end

   assign reg_rdata_o = rdata_reg;
   assign err_frame_o = err_frame_reg;
   assign int_n_o = int_n_reg;
   assign full_pin_o = pin_reg;
   assign full_pin_oe_o = pin_oe_reg;
endmodule // crbc_top

// File: crbc_top_chk.sv
/* checker of the receive buffer control top module ports.
   assumes it is bound to crbc_top, one clock domain. */
`timescale 1ns/100ps
module crbc_top_chk (
   input wire logic clk_sys_i,
   input wire logic rstn_i,
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   input wire logic [7:0] reg_addr_i,
   input wire logic [7:0] reg_wdata_i,
   input wire logic [7:0] reg_mask_i,
   input wire logic [7:0] reg_rdata_o,
   input wire logic msg_valid_i,
   input wire logic msg_ready_o,
   input wire logic msg_err_i,
   input wire logic err_frame_o,
   input wire logic int_n_o,
   input wire logic [1:0] full_pin_o,
   input wire logic [1:0] full_pin_oe_o
);
   logic [5:0] pc_reg, pc_next;
   logic [4:0] tk_reg, tk_next, cl_reg, cl_next;
   logic take, i0, i1;
   logic [7:0] pc_rd;
   assign take = msg_valid_i && msg_ready_o;
   assign i0 = pc_reg[2] && pc_reg[0];
   assign i1 = pc_reg[3] && pc_reg[1];
   assign pc_rd = {2'b00, pc_reg[5:4] & ~{i1, i0}, pc_reg[3:0]};
   // pin control shadow, cycles since last take and last flag write
   always_comb begin
      pc_next = pc_reg;
      if (reg_wr_i && reg_addr_i == 8'h0c) begin
         pc_next = (pc_reg & ~reg_mask_i[5:0]) | (reg_wdata_i[5:0] & reg_mask_i[5:0]);
      end
      tk_next = take ? 5'h00 : tk_reg + 5'(tk_reg != 5'h1f);
      cl_next = (reg_wr_i && reg_addr_i == 8'h2c) ? 5'h00 : cl_reg + 5'(cl_reg != 5'h1f);
   end
   always_ff @(posedge clk_sys_i or negedge rstn_i) begin
      if (!rstn_i) begin
         pc_reg <= 6'h00;
         tk_reg <= 5'h1f;
         cl_reg <= 5'h1f;
      end else begin
         pc_reg <= pc_next;
         tk_reg <= tk_next;
         cl_reg <= cl_next;
      end
   end
   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (!rstn_i);
   sequence s_bad_take;
      take && msg_err_i;
   endsequence
   sequence s_rd(logic [7:0] a);
      reg_rd_i && reg_addr_i == a;
   endsequence
   chk_pin_oe: assert property (full_pin_oe_o == $past(pc_reg[3:2]))
      else $error("pin enable mismatch");
   chk_pin0_level: assert property ($past(pc_reg[2] && !pc_reg[0]) |->
      full_pin_o[0] == $past(pc_reg[4])) else $error("pin0 level mismatch");
   chk_pin1_level: assert property ($past(pc_reg[3] && !pc_reg[1]) |->
      full_pin_o[1] == $past(pc_reg[5])) else $error("pin1 level mismatch");
   chk_lvl_read: assert property (s_rd(8'h0c) |=> reg_rdata_o == $past(pc_rd))
      else $error("pin control read mismatch");
   chk_ctrl0_bits: assert property (s_rd(8'h60) |=> !reg_rdata_o[7] && !reg_rdata_o[4]
      && reg_rdata_o[1] == reg_rdata_o[2]) else $error("control0 read mismatch");
   chk_ctrl1_bits: assert property (s_rd(8'h70) |=> !reg_rdata_o[7] && !reg_rdata_o[4])
      else $error("control1 read mismatch");
   chk_idlow_gap: assert property (s_rd(8'h62) or s_rd(8'h72) |=> !reg_rdata_o[2])
      else $error("id low gap bit set");
   chk_err_frame: assert property (s_bad_take |=> err_frame_o)
      else $error("error frame missing");
   chk_err_cause: assert property (err_frame_o |-> $past(take && msg_err_i))
      else $error("error frame without cause");
   chk_pin_release: assert property ($rose(full_pin_o[0]) && i0 && $past(i0, 4) |->
      cl_reg < 5'd6) else $error("pin0 released without flag write");
   chk_pin_fall: assert property ($fell(full_pin_o[1]) && i1 && $past(i1, 4) |->
      tk_reg < 5'd24) else $error("pin1 fell without message");
   chk_int_cause: assert property ($fell(int_n_o) |-> tk_reg < 5'd24)
      else $error("interrupt without message");
endmodule // crbc_top_chk
bind crbc_top crbc_top_chk i_crbc_top_chk (.clk_sys_i(clk_sys_i), .rstn_i(rstn_i),
   .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_addr_i(reg_addr_i),
   .reg_wdata_i(reg_wdata_i), .reg_mask_i(reg_mask_i), .reg_rdata_o(reg_rdata_o),
   .msg_valid_i(msg_valid_i), .msg_ready_o(msg_ready_o), .msg_err_i(msg_err_i),
   .err_frame_o(err_frame_o), .int_n_o(int_n_o), .full_pin_o(full_pin_o),
   .full_pin_oe_o(full_pin_oe_o));

// File: crbc_msg_src.sv
/* message source standing in for the protocol engine and filters.
   assumes the valid/ready message port of crbc_top. */
`timescale 1ns/100ps
module crbc_msg_src
   import crbc_pkg::*;
(
   input wire logic clk_sys_i,
   input wire logic rstn_i,
   input wire logic msg_ready_i,
   output logic msg_valid_o,
   output crbc_msg_s msg_o
);
   crbc_msg_s q[$];
   task automatic push(input crbc_msg_s m);
      q.push_back(m);
   endtask
   // offer held until taken
   always @(posedge clk_sys_i or negedge rstn_i) begin
      if (!rstn_i) begin
         msg_valid_o <= 1'b0;
         msg_o <= '0;
      end else if (!msg_valid_o || msg_ready_i) begin
         if (q.size() > 0) begin
            msg_valid_o <= 1'b1;
            msg_o <= q.pop_front();
         end else begin
            msg_valid_o <= 1'b0;
            msg_o <= ~msg_o;
         end
      end
   end
endmodule // crbc_msg_src

// File: crbc_top_tb.sv
/* testbench of the receive buffer control block: register tasks and scenarios.
   assumes crbc_top, its bound checker and the crbc_msg_src model. */
`timescale 1ns/100ps
module crbc_top_tb
   import crbc_pkg::*;
;
   logic clk_sys_i = 1'b0;
   logic rstn_i;
   logic reg_wr_i = 1'b0;
   logic reg_rd_i = 1'b0;
   logic [7:0] reg_addr_i = 8'h00;
   logic [7:0] reg_wdata_i = 8'h00;
   logic [7:0] reg_mask_i = 8'hff;
   logic [7:0] reg_rdata_o;
   logic msg_valid_i, msg_ready_o, err_frame_o, int_n_o;
   logic [1:0] full_pin_o, full_pin_oe_o;
   crbc_msg_s msg;
   int err_total = 0;
   int checks = 0;
   int n;
   logic [1:0] mode_tab [10] = '{0, 0, 1, 1, 2, 2, 3, 0, 0, 1};
   logic [2:0] kind_tab [10] = '{0, 2, 0, 2, 0, 2, 4, 4, 0, 0};
   logic [9:0] acc_tab = 10'h267;
   always #5 clk_sys_i = ~clk_sys_i;
   crbc_msg_src i_crbc_msg_src (.clk_sys_i(clk_sys_i), .rstn_i(rstn_i),
      .msg_ready_i(msg_ready_o), .msg_valid_o(msg_valid_i), .msg_o(msg));
   crbc_top i_crbc_top (.clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .reg_wr_i(reg_wr_i),
      .reg_rd_i(reg_rd_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
      .reg_mask_i(reg_mask_i), .reg_rdata_o(reg_rdata_o), .msg_valid_i(msg_valid_i),
      .msg_ready_o(msg_ready_o), .msg_err_i(msg.err), .msg_sid_i(msg.id.standard_identifier),
      .msg_srr_i(msg.id.srr), .msg_ide_i(msg.id.ide), .msg_eid_i(msg.id.extended_identifier),
      .msg_rtr_i(msg.id.rtr), .msg_id_match_i(msg.id_match),
      .msg_data_match_i(msg.data_match), .filt_ext_i(6'h30), .err_frame_o(err_frame_o),
      .int_n_o(int_n_o), .full_pin_o(full_pin_o), .full_pin_oe_o(full_pin_oe_o));
   task automatic final_report();
      $display("checks %0d errors %0d", checks, err_total);
      if (err_total == 0 && checks > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
      checks++;
      if (got !== exp) begin
         err_total++;
         $display("ERROR %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [7:0] m);
      @(posedge clk_sys_i);
      reg_wr_i <= 1'b1;
      reg_addr_i <= a;
      reg_wdata_i <= d;
      reg_mask_i <= m;
      @(posedge clk_sys_i);
      reg_wr_i <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      @(posedge clk_sys_i);
      reg_rd_i <= 1'b1;
      reg_addr_i <= a;
      @(posedge clk_sys_i);
      reg_rd_i <= 1'b0;
      #1;
      chk($sformatf("reg %h", a), exp, reg_rdata_o);
   endtask
   task automatic pins(input logic [1:0] lv, input logic [1:0] oe, input logic irq_n);
      repeat (3) @(posedge clk_sys_i);
      #1;
      chk("pin oe", {6'h00, oe}, {6'h00, full_pin_oe_o});
      chk("pin level", {6'h00, lv & oe}, {6'h00, full_pin_o & oe});
      chk("int_n", {7'h00, irq_n}, {7'h00, int_n_o});
   endtask
   // kind bits: errored, extended, remote
   function automatic crbc_msg_s mk(input logic [10:0] standard_identifier, input logic [2:0] k,
      input logic [5:0] idm, input logic [5:0] dm);
      return '{'{standard_identifier, k[0] & ~k[1], k[1], 2'b10, k[0] & k[1]}, k[2], idm, dm};
   endfunction
   task automatic send(input logic [10:0] standard_identifier, input logic [2:0] k, input logic [5:0] idm,
      input logic [5:0] dm);
      @(negedge clk_sys_i);
      i_crbc_msg_src.push(mk(standard_identifier, k, idm, dm));
      n = 0;
      while ((i_crbc_msg_src.q.size() > 0 || msg_valid_i) && n < 300) begin
         @(posedge clk_sys_i);
         n++;
      end
      repeat (6) @(posedge clk_sys_i);
   endtask
   initial begin
      rstn_i = 1'b0;
      repeat (5) @(posedge clk_sys_i);
      rstn_i <= 1'b1;
      foreach (kind_tab[i]) rd(i < 6 ? {i[3:0], 4'hc} - 8'h10 : 8'h00, 8'h00);
      rd(8'h60, 8'h00);
      rd(8'h70, 8'h00);
      rd(8'h5f, 8'h00);
      wr(8'h0c, 8'hff, 8'hff);
      rd(8'h0c, 8'h0f);
      pins(2'b11, 2'b11, 1'b1);
      wr(8'h0c, 8'h3c, 8'hff);
      pins(2'b11, 2'b11, 1'b1);
      wr(8'h0c, 8'h00, 8'h10);
      pins(2'b10, 2'b11, 1'b1);
      wr(8'h0c, 8'h00, 8'h08);
      pins(2'b10, 2'b01, 1'b1);
      rd(8'h0c, 8'h24);
      wr(8'h0c, 8'h0f, 8'hff);
      wr(8'h2b, 8'h23, 8'hff);
      send(11'h5a3, 3'b001, 6'h0a, 6'h3f);
      rd(8'h2c, 8'h01);
      rd(8'h60, 8'h09);
      rd(8'h61, 8'hb4);
      rd(8'h62, 8'h72);
      pins(2'b10, 2'b11, 1'b0);
      send(11'h001, 3'b000, 6'h01, 6'h3f);
      rd(8'h2d, 8'h40);
      rd(8'h2c, 8'h21);
      rd(8'h61, 8'hb4);
      wr(8'h2c, 8'h00, 8'hff);
      wr(8'h2d, 8'h00, 8'hff);
      pins(2'b11, 2'b11, 1'b1);
      for (int i = 0; i < 10; i++) begin
         wr(8'h70, {1'b0, mode_tab[i], 5'h00}, 8'hff);
         send(11'h123, kind_tab[i], kind_tab[i][1] ? 6'h10 : 6'h04, i < 8 ? 6'h3f : 6'h00);
         rd(8'h2c, {6'h00, acc_tab[i], 1'b0});
         wr(8'h2c, 8'h00, 8'hff);
      end
      wr(8'h70, 8'h00, 8'hff);
      send(11'h123, 3'b011, 6'h10, 6'h3f);
      rd(8'h70, 8'h0c);
      rd(8'h72, 8'h6a);
      wr(8'h2c, 8'h00, 8'hff);
      wr(8'h60, 8'h04, 8'hff);
      rd(8'h60, 8'h0f);
      send(11'h011, 3'b000, 6'h01, 6'h3f);
      send(11'h022, 3'b000, 6'h02, 6'h3f);
      rd(8'h2c, 8'h03);
      rd(8'h70, 8'h01);
      rd(8'h71, 8'h04);
      send(11'h033, 3'b000, 6'h01, 6'h3f);
      rd(8'h2d, 8'h80);
      wr(8'h2c, 8'h00, 8'hff);
      wr(8'h2d, 8'h00, 8'hff);
      // flag writes stall the drain, so the fifo fills
      @(negedge clk_sys_i);
      repeat (20) i_crbc_msg_src.push(mk(11'h7ff, 3'b000, 6'h00, 6'h00));
      @(posedge clk_sys_i);
      reg_wr_i <= 1'b1;
      reg_addr_i <= 8'h2c;
      reg_mask_i <= 8'h00;
      n = 0;
      repeat (40) begin
         @(posedge clk_sys_i);
         n += (msg_ready_o === 1'b0);
      end
      reg_wr_i <= 1'b0;
      chk("fifo refused", 8'h01, {7'h00, n > 0});
      send(11'h7ff, 3'b000, 6'h00, 6'h00);
      chk("fifo ready", 8'h01, {7'h00, msg_ready_o});
      rd(8'h2c, 8'h00);
      final_report();
   end
   initial begin
      #200us;
      err_total++;
      $display("ERROR watchdog expected end seen timeout");
      final_report();
   end
endmodule // crbc_top_tb
